// *** rtl/pwr_mode_ctrl.sv ***
`timescale 1ns/1ps
`include "pwr_consts.svh"

module pwr_mode_ctrl #(
    parameter int MS_CYCLES = `CLK_HZ / `MS_PER_S
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Pins
    input wire logic rst_shut_pin,
    input wire logic load_detect_pin,
    input wire logic supply_low_pin,
    // Measurement results
    input wire logic [15:0] slow_current_reading,
    input wire logic slow_current_valid,
    input wire logic [15:0] fast_check_current,
    input wire logic fast_check_valid,
    input wire logic [15:0] pack_mv,
    input wire logic [15:0] stack_mv,
    input wire logic volt_valid,
    input wire logic meas_loop_done,
    // Events and requests
    input wire logic sleep_strap,
    input wire logic protection_fault,
    input wire logic charger_attach,
    input wire logic fast_osc_need,
    // Measurement control
    output logic meas_current_tick,
    output logic meas_voltage_tick,
    output logic fast_check_tick,
    output logic fast_conv,
    output logic protections_en,
    output logic comparators_en,
    // Switches and power
    output logic discharge_switch_en,
    output logic discharge_source_follower,
    output logic charge_switch_en,
    output logic precharge_switch_en,
    output logic predischarge_switch_en,
    output logic auxiliary_regulator_en,
    output logic slow_oscillator_en,
    output logic slow_oscillator_fast,
    output logic fast_oscillator_en,
    output logic logic_reset,
    output logic power_off
);

    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
    localparam logic [9:0] SEC_LAST = 10'(`MS_PER_S - 1);
    localparam logic [1:0] CUR_LAST = 2'(`CUR_PERIOD_MS - 1);
    localparam logic [3:0] CHK_LAST = 4'(`SLEEP_CHECK_MS - 1);
    localparam logic [7:0] DX_LAST = 8'(`DEEP_EXIT_MS - 1);
    localparam logic [9:0] RST_LAST = 10'(`RST_SHUT_MS - 1);

    if (MS_CYCLES < 1 || MS_CYCLES > 65536) begin : g_bad_ms
        $error("MS_CYCLES out of range");
    end

    function automatic logic [15:0] mag(input logic [15:0] v);
        mag = v[15] ? 16'(-v) : v;
    endfunction

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [2:0] pin_m_r, pin_s_r;
    logic rst_d_r, ld_d_r;
    always_ff @(posedge clk) begin
        pin_m_r <= {supply_low_pin, load_detect_pin, rst_shut_pin};
        pin_s_r <= pin_m_r;
        rst_d_r <= pin_s_r[0];
        ld_d_r <= pin_s_r[1];
    end
    wire rst_s = pin_s_r[0];
    wire ld_rise = pin_s_r[1] && !ld_d_r;
    wire supply_low = pin_s_r[2];
    assign logic_reset = rst_s;

    // ************************************************
    // Registers and bus
    // ************************************************
    pwr_pkg::mode_t mode_r, mode_nxt;
    logic [31:0] ctrl_r, curthr_r, packthr_r, time_r, hrdata_r;
    logic [6:0] cmd_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic sleep_allowed_r, init_r, meas_hold_r;
    logic [7:0] hyst_cnt_r;

    wire accept = hsel && hready && htrans[1];
    wire in_shut = mode_r == pwr_pkg::M_SHUTDOWN;
    wire wr_ctrl = wr_pend_r && wr_addr_r == `A_CTRL;
    wire wr_cmd = wr_pend_r && wr_addr_r == `A_CMD && !in_shut;
    wire wr_cur = wr_pend_r && wr_addr_r == `A_CURTHR;
    wire wr_pack = wr_pend_r && wr_addr_r == `A_PACKTHR;
    wire wr_time = wr_pend_r && wr_addr_r == `A_TIME;
    wire [31:0] stat_w = {25'h0, hyst_cnt_r != 8'h00, meas_hold_r,
        mode_r == pwr_pkg::M_SLEEP, sleep_allowed_r, mode_r};
    wire [31:0] rdata_nxt = haddr[7:0] == `A_CTRL ? ctrl_r :
        haddr[7:0] == `A_STAT ? stat_w :
        haddr[7:0] == `A_CURTHR ? curthr_r :
        haddr[7:0] == `A_PACKTHR ? packthr_r :
        haddr[7:0] == `A_TIME ? time_r : 32'h0;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0;
        end else begin
            wr_pend_r <= accept && hwrite;
            wr_addr_r <= haddr[7:0];
            if (accept && !hwrite) begin
                hrdata_r <= rdata_nxt;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || in_shut) begin
            ctrl_r <= `CTRL_RST;
            curthr_r <= `CURTHR_RST;
            packthr_r <= `PACKTHR_RST;
            time_r <= `TIME_RST;
            cmd_r <= 7'h00;
        end else begin
            if (wr_ctrl) ctrl_r <= hwdata;
            if (wr_cur) curthr_r <= hwdata;
            if (wr_pack) packthr_r <= hwdata;
            if (wr_time) time_r <= hwdata;
            cmd_r <= wr_cmd ? hwdata[6:0] : 7'h00;
        end
    end

    wire [15:0] relax_thr = curthr_r[15:0];
    wire [15:0] wake_thr = curthr_r[31:16];
    wire [15:0] pack_delta = packthr_r[15:0];
    wire [15:0] stack_thr = packthr_r[31:16];
    wire [7:0] hyst_s = time_r[7:0];
    wire [7:0] int_s = time_r[15:8];
    wire [3:0] vmult = ctrl_r[`CTRL_VMULT_MSB:`CTRL_VMULT_LSB];
    assign fast_conv = ctrl_r[`CTRL_FAST_CONV];

    // ************************************************
    // Time base
    // ************************************************
    logic [15:0] ms_cnt_r;
    logic [9:0] sec_cnt_r, rst_cnt_r;
    logic [1:0] cur_cnt_r;
    logic [8:0] volt_cnt_r;
    logic [3:0] chk_cnt_r;
    logic [7:0] int_cnt_r, dx_cnt_r;
    logic loop_req_r;

    wire ms_tick = ms_cnt_r == MS_LAST;
    wire sec_tick = ms_tick && sec_cnt_r == SEC_LAST;
    wire cur_due = ms_tick && cur_cnt_r == CUR_LAST;
    wire [8:0] volt_last = 9'(`VOLT_PERIOD_MS * ({5'h0, vmult} + 9'h1) - 1);
    wire volt_due = ms_tick && volt_cnt_r >= volt_last;
    wire chk_due = ms_tick && chk_cnt_r == CHK_LAST;
    wire [7:0] int_last = int_s == 8'h00 ? 8'h00 : int_s - 8'h01;
    wire int_due = sec_tick && int_cnt_r >= int_last;
    wire dx_done = dx_cnt_r == DX_LAST;
    wire loop_go = mode_r == pwr_pkg::M_DEEP_EXIT && dx_done && !loop_req_r;
    wire rst_long = rst_s && ms_tick && rst_cnt_r == RST_LAST;
    wire rst_short = rst_d_r && !rst_s;
    wire in_sleep = mode_r == pwr_pkg::M_SLEEP;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ms_cnt_r <= 16'h0;
            sec_cnt_r <= 10'h0;
            cur_cnt_r <= 2'h0;
            volt_cnt_r <= 9'h0;
        end else begin
            ms_cnt_r <= ms_tick ? 16'h0 : ms_cnt_r + 16'h1;
            if (ms_tick) begin
                sec_cnt_r <= sec_tick ? 10'h0 : sec_cnt_r + 10'h1;
                cur_cnt_r <= cur_due ? 2'h0 : cur_cnt_r + 2'h1;
                volt_cnt_r <= volt_due ? 9'h0 : volt_cnt_r + 9'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chk_cnt_r <= 4'h0;
            int_cnt_r <= 8'h0;
            dx_cnt_r <= 8'h0;
            loop_req_r <= 1'b0;
            rst_cnt_r <= 10'h0;
        end else begin
            if (!in_sleep) chk_cnt_r <= 4'h0;
            else if (ms_tick) chk_cnt_r <= chk_due ? 4'h0 : chk_cnt_r + 4'h1;
            if (!in_sleep) int_cnt_r <= 8'h0;
            else if (sec_tick) int_cnt_r <= int_due ? 8'h0 : int_cnt_r + 8'h1;
            if (mode_r != pwr_pkg::M_DEEP_EXIT) begin
                dx_cnt_r <= 8'h0;
                loop_req_r <= 1'b0;
            end else begin
                if (ms_tick && !dx_done) dx_cnt_r <= dx_cnt_r + 8'h1;
                if (loop_go) loop_req_r <= 1'b1;
            end
            if (!rst_s) rst_cnt_r <= 10'h0;
            else if (ms_tick && rst_cnt_r != RST_LAST) rst_cnt_r <= rst_cnt_r + 10'h1;
        end
    end

    // ************************************************
    // Mode sequencing
    // ************************************************
    wire relax = slow_current_valid && mag(slow_current_reading) < relax_thr;
    wire cur_wake = (fast_check_valid && mag(fast_check_current) > wake_thr)
        || (slow_current_valid && mag(slow_current_reading) > wake_thr);
    wire pack_wake = volt_valid && pack_mv > stack_mv
        && pack_mv - stack_mv > pack_delta && stack_mv < stack_thr;
    wire sleep_exit = protection_fault || cur_wake || charger_attach
        || cmd_r[`CMD_SLEEP_EXIT] || cmd_r[`CMD_SLEEP_DENY] || rst_short || pack_wake;
    wire deep_wake = cmd_r[`CMD_DEEP_EXIT] || rst_short || ld_rise;

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            pwr_pkg::M_NORMAL: begin
                if (cmd_r[`CMD_CFG_ENTER]) mode_nxt = pwr_pkg::M_CFG;
                else if (cmd_r[`CMD_DEEP_ENTER]) mode_nxt = pwr_pkg::M_DEEP;
                else if (sleep_allowed_r && relax && hyst_cnt_r == 8'h00
                    && !protection_fault) mode_nxt = pwr_pkg::M_SLEEP;
            end
            pwr_pkg::M_SLEEP: begin
                if (cmd_r[`CMD_DEEP_ENTER]) mode_nxt = pwr_pkg::M_DEEP;
                else if (sleep_exit) mode_nxt = pwr_pkg::M_NORMAL;
            end
            pwr_pkg::M_DEEP: begin
                if (supply_low) mode_nxt = pwr_pkg::M_SHUTDOWN;
                else if (deep_wake) mode_nxt = pwr_pkg::M_DEEP_EXIT;
            end
            pwr_pkg::M_DEEP_EXIT: begin
                if (loop_req_r && meas_loop_done) mode_nxt = pwr_pkg::M_NORMAL;
            end
            pwr_pkg::M_CFG: begin
                if (cmd_r[`CMD_CFG_EXIT]) mode_nxt = pwr_pkg::M_NORMAL;
            end
            pwr_pkg::M_SHUTDOWN: mode_nxt = pwr_pkg::M_SHUTDOWN;
            default: mode_nxt = pwr_pkg::M_NORMAL;
        endcase
        if (rst_long) mode_nxt = pwr_pkg::M_SHUTDOWN;
    end

    wire to_normal = mode_nxt == pwr_pkg::M_NORMAL
        && (in_sleep || mode_r == pwr_pkg::M_DEEP_EXIT);
    wire hold_set = in_sleep && to_normal && cur_wake;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_r <= pwr_pkg::M_NORMAL;
            sleep_allowed_r <= 1'b0;
            init_r <= 1'b0;
            meas_hold_r <= 1'b0;
            hyst_cnt_r <= 8'h0;
        end else begin
            mode_r <= mode_nxt;
            init_r <= 1'b1;
            if (!init_r) sleep_allowed_r <= sleep_strap;
            else if (cmd_r[`CMD_SLEEP_ALLOW]) sleep_allowed_r <= 1'b1;
            else if (cmd_r[`CMD_SLEEP_DENY]) sleep_allowed_r <= 1'b0;
            if (hold_set) meas_hold_r <= 1'b1;
            else if (sec_tick) meas_hold_r <= 1'b0;
            if (to_normal) hyst_cnt_r <= hyst_s;
            else if (sec_tick && hyst_cnt_r != 8'h00) hyst_cnt_r <= hyst_cnt_r - 8'h1;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    wire n_norm = mode_nxt == pwr_pkg::M_NORMAL || mode_nxt == pwr_pkg::M_CFG;
    wire n_sleep = mode_nxt == pwr_pkg::M_SLEEP;
    wire n_deep = mode_nxt == pwr_pkg::M_DEEP;
    wire n_shut = mode_nxt == pwr_pkg::M_SHUTDOWN;
    wire n_meas = mode_nxt == pwr_pkg::M_NORMAL && !meas_hold_r && !hold_set;
    wire dsg_nxt = n_norm || n_sleep;
    wire chg_nxt = n_norm || (n_sleep && !ctrl_r[`CTRL_SLEEP_CHG_OFF]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meas_current_tick <= 1'b0;
            meas_voltage_tick <= 1'b0;
            fast_check_tick <= 1'b0;
            protections_en <= 1'b0;
            comparators_en <= 1'b0;
            discharge_switch_en <= 1'b0;
            discharge_source_follower <= 1'b0;
            charge_switch_en <= 1'b0;
            precharge_switch_en <= 1'b0;
            predischarge_switch_en <= 1'b0;
            auxiliary_regulator_en <= 1'b0;
            slow_oscillator_en <= 1'b0;
            slow_oscillator_fast <= 1'b0;
            fast_oscillator_en <= 1'b0;
            power_off <= 1'b0;
        end else begin
            meas_current_tick <= (n_meas && cur_due) || (n_sleep && int_due) || loop_go;
            meas_voltage_tick <= (n_meas && volt_due) || (n_sleep && int_due) || loop_go;
            fast_check_tick <= n_sleep && chk_due;
            protections_en <= mode_nxt == pwr_pkg::M_NORMAL || n_sleep
                || mode_nxt == pwr_pkg::M_DEEP_EXIT;
            comparators_en <= mode_nxt == pwr_pkg::M_NORMAL || n_sleep;
            discharge_switch_en <= dsg_nxt;
            discharge_source_follower <= n_sleep && ctrl_r[`CTRL_SLEEP_DSG_SF];
            charge_switch_en <= chg_nxt;
            precharge_switch_en <= chg_nxt && !n_sleep;
            predischarge_switch_en <= dsg_nxt && !n_sleep;
            auxiliary_regulator_en <= !n_shut && (!n_deep || ctrl_r[`CTRL_DEEP_AUX_KEEP]);
            slow_oscillator_en <= !n_shut && (!n_deep || ctrl_r[`CTRL_DEEP_SLOW_KEEP]);
            slow_oscillator_fast <= n_norm || mode_nxt == pwr_pkg::M_DEEP_EXIT;
            fast_oscillator_en <= fast_osc_need && !n_shut;
            power_off <= n_shut;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    shut_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        in_shut |=> in_shut && power_off && !discharge_switch_en && !auxiliary_regulator_en)
        else $error("shutdown left or outputs live");
    deep_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode_r == pwr_pkg::M_DEEP |-> !discharge_switch_en && !charge_switch_en
            && !protections_en && !meas_current_tick)
        else $error("deep mode outputs active");
    sleep_dsg_a: assert property (@(posedge clk) disable iff (!rst_n)
        in_sleep |-> discharge_switch_en && !slow_oscillator_fast && slow_oscillator_en)
        else $error("sleep switch or oscillator wrong");
    normal_osc_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode_r == pwr_pkg::M_NORMAL && $past(rst_n)
            |-> slow_oscillator_en && slow_oscillator_fast)
        else $error("normal oscillator wrong");
    long_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        rst_long |=> in_shut)
        else $error("long pin did not shut down");
    hyst_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode_r == pwr_pkg::M_NORMAL && hyst_cnt_r != 8'h00 |=> !in_sleep)
        else $error("sleep during hysteresis");
    sleep_permit_a: assert property (@(posedge clk) disable iff (!rst_n)
        in_sleep && $past(mode_r) == pwr_pkg::M_NORMAL |-> $past(sleep_allowed_r))
        else $error("sleep without permit");
    deep_exit_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode_r == pwr_pkg::M_DEEP_EXIT && !loop_req_r |=> mode_r != pwr_pkg::M_NORMAL)
        else $error("deep exit too early");
    hold_meas_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(meas_hold_r) |-> !meas_current_tick [*2])
        else $error("measurement during hold");
    deep_supply_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode_r == pwr_pkg::M_DEEP && supply_low |=> in_shut)
        else $error("supply low ignored in deep");

endmodule // pwr_mode_ctrl

// *** rtl/pwr_consts.svh ***
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH

// ************************************************
// Timing, in milliseconds unless named otherwise
// ************************************************
`define CLK_HZ 40000000
`define MS_PER_S 1000
`define CUR_PERIOD_MS 3
`define VOLT_PERIOD_MS 30
`define SLEEP_CHECK_MS 12
`define DEEP_EXIT_MS 250
`define RST_SHUT_MS 1000
`define SLOW_OSC_RUN_HZ 262144
`define SLOW_OSC_LOW_HZ 32768
`define FAST_OSC_HZ 16780000

// ************************************************
// Register offsets
// ************************************************
`define A_CTRL 8'h00
`define A_CMD 8'h04
`define A_STAT 8'h08
`define A_CURTHR 8'h0c
`define A_PACKTHR 8'h10
`define A_TIME 8'h14

// ************************************************
// Field positions
// ************************************************
`define CTRL_FAST_CONV 0
`define CTRL_SLEEP_CHG_OFF 1
`define CTRL_SLEEP_DSG_SF 2
`define CTRL_DEEP_SLOW_KEEP 3
`define CTRL_DEEP_AUX_KEEP 4
`define CTRL_VMULT_LSB 8
`define CTRL_VMULT_MSB 11
`define CMD_SLEEP_ALLOW 0
`define CMD_SLEEP_DENY 1
`define CMD_SLEEP_EXIT 2
`define CMD_DEEP_ENTER 3
`define CMD_DEEP_EXIT 4
`define CMD_CFG_ENTER 5
`define CMD_CFG_EXIT 6

// ************************************************
// Reset values
// ************************************************
`define CTRL_RST 32'h0000_0010
`define CURTHR_RST 32'h0064_000a
`define PACKTHR_RST 32'h2ee0_0190
`define TIME_RST 32'h0000_0505

`endif

// *** rtl/pwr_pkg.sv ***
package pwr_pkg;

    typedef enum logic [2:0] {
        M_NORMAL,
        M_SLEEP,
        M_DEEP,
        M_DEEP_EXIT,
        M_SHUTDOWN,
        M_CFG
    } mode_t;

endpackage

// *** tb/pwr_host_model.sv ***
`timescale 1ns/1ps
`include "pwr_consts.svh"

module pwr_host_model (
    // Bus clock
    input wire logic clk,
    // AHB-Lite master side
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // ************************************************
    // Single word transfer, held until hready
    // ************************************************
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // Host subcommands travel as writes to the command word
    task automatic cmd(input int b);
        logic [31:0] rd;
        xfer(1'b1, `A_CMD, 32'h1 << b, rd);
    endtask
endmodule // pwr_host_model

// *** tb/battery_monitor_power_modes_bench.sv ***
`timescale 1ns/1ps
`include "pwr_consts.svh"

module battery_monitor_power_modes_bench;
    logic clk = 1'b0, rst_n = 1'b0, hsel, hwrite, hready, hresp_unused;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic rsp = 1'b0, ldp = 1'b0, slp = 1'b0, scv = 1'b0, fcv = 1'b0, ldone = 1'b0;
    logic strap = 1'b1, fault = 1'b0, chg_att = 1'b0, fneed = 1'b0, vv = 1'b0;
    logic [15:0] sci = 16'h0000, fci = 16'h0000, pmv = 16'h0000, smv = 16'h0000;
    logic cur_t, volt_t, fconv, prot, dsw, csw, pcs, pds, aux, so_en, so_fast, fo_en, lrst, poff;
    logic fchk, dsf, comp;
    wire [2:0] ticks = {fchk, volt_t, cur_t};
    int err_total = 0, checks = 0, n;

    always #12.5 clk = ~clk;

    pwr_mode_ctrl #(.MS_CYCLES(4)) i_pwr_mode_ctrl (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp_unused), .hrdata(hrdata),
        .rst_shut_pin(rsp), .load_detect_pin(ldp), .supply_low_pin(slp),
        .slow_current_reading(sci), .slow_current_valid(scv), .fast_check_current(fci),
        .fast_check_valid(fcv), .pack_mv(pmv), .stack_mv(smv), .volt_valid(vv),
        .meas_loop_done(ldone), .sleep_strap(strap), .protection_fault(fault),
        .charger_attach(chg_att), .fast_osc_need(fneed), .meas_current_tick(cur_t),
        .meas_voltage_tick(volt_t), .fast_check_tick(fchk), .fast_conv(fconv),
        .protections_en(prot), .comparators_en(comp), .discharge_switch_en(dsw),
        .discharge_source_follower(dsf), .charge_switch_en(csw), .precharge_switch_en(pcs),
        .predischarge_switch_en(pds), .auxiliary_regulator_en(aux), .slow_oscillator_en(so_en),
        .slow_oscillator_fast(so_fast), .fast_oscillator_en(fo_en), .logic_reset(lrst),
        .power_off(poff));

    pwr_host_model i_pwr_host_model (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // ************************************************
    // Shared helpers
    // ************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic rdreg(input logic [7:0] a);
        i_pwr_host_model.xfer(1'b0, a, 32'h0, rd);
    endtask

    task automatic wrreg(input logic [7:0] a, input logic [31:0] d);
        i_pwr_host_model.xfer(1'b1, a, d, rd);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(2);
    endtask

    task automatic tick_gap(input int sel);
        do @(posedge clk); while (ticks[sel] !== 1'b1);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ticks[sel] !== 1'b1);
    endtask

    task automatic pulse_cur(input logic fast, input logic [15:0] i);
        if (fast) begin
            fci <= i;
            fcv <= 1'b1;
        end else begin
            sci <= i;
            scv <= 1'b1;
        end
        @(posedge clk);
        fcv <= 1'b0;
        scv <= 1'b0;
        cyc(4);
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_reset_normal();
        chk({dsw, csw, prot, so_en, so_fast}, 32'h1f);
        chk({hready, hresp_unused}, 32'h2);
        rdreg(`A_STAT);
        chk(rd[3:0], 32'h8);
        rdreg(`A_CTRL);
        chk(rd, `CTRL_RST);
        rdreg(`A_CURTHR);
        chk(rd, `CURTHR_RST);
        rdreg(8'h18);
        chk(rd, 32'h0);
        tick_gap(1'b0);
        chk(n, `CUR_PERIOD_MS * 4);
        tick_gap(1'b1);
        chk(n, `VOLT_PERIOD_MS * 4);
        fneed <= 1'b1;
        cyc(3);
        chk(fo_en, 1'b1);
        fneed <= 1'b0;
        wrreg(`A_CTRL, 32'h13);
        cyc(2);
        chk(fconv, 1'b1);
        chk(fo_en, 1'b0);
    endtask

    task automatic t_sleep();
        i_pwr_host_model.cmd(`CMD_SLEEP_DENY);
        cyc(4);
        pulse_cur(1'b0, 16'hfffb);
        rdreg(`A_STAT);
        chk(rd[4:0], 32'h0);
        i_pwr_host_model.cmd(`CMD_SLEEP_ALLOW);
        cyc(4);
        pulse_cur(1'b0, 16'hfffb);
        rdreg(`A_STAT);
        chk(rd[4:0], 32'h19);
        chk({dsw, csw, so_fast, prot}, 32'h9);
        pulse_cur(1'b1, 16'h00c8);
        rdreg(`A_STAT);
        chk(rd[6:0], 32'h68);
        chk({dsw, csw, so_fast}, 32'h7);
        pulse_cur(1'b0, 16'h0002);
        rdreg(`A_STAT);
        chk(rd[2:0], 32'h0);
    endtask

    task automatic t_edit();
        i_pwr_host_model.cmd(`CMD_CFG_ENTER);
        cyc(4);
        rdreg(`A_STAT);
        chk({rd[2:0], prot}, 32'ha);
        i_pwr_host_model.cmd(`CMD_CFG_EXIT);
        cyc(4);
        chk(prot, 1'b1);
    endtask

    task automatic deep_wake(input int how);
        i_pwr_host_model.cmd(`CMD_DEEP_ENTER);
        cyc(4);
        chk({dsw, csw, pcs, pds, prot, aux, so_en, so_fast}, 32'h04);
        wrreg(`A_PACKTHR, 32'h2ee0_0190);
        rdreg(`A_STAT);
        chk(rd[2:0], 32'h2);
        case (how)
            0: ldp <= 1'b1;
            1: i_pwr_host_model.cmd(`CMD_DEEP_EXIT);
            default: rsp <= 1'b1;
        endcase
        cyc(2);
        rsp <= 1'b0;
        cyc(5);
        rdreg(`A_STAT);
        chk(rd[2:0], 32'h3);
        n = 0;
        while (volt_t !== 1'b1 && n < 1200) begin
            @(posedge clk);
            n++;
        end
        chk(n > 900 && n < 1200, 1'b1);
        ldone <= 1'b1;
        @(posedge clk);
        ldone <= 1'b0;
        cyc(4);
        rdreg(`A_STAT);
        chk(rd[2:0], 32'h0);
        ldp <= 1'b0;
    endtask

    task automatic t_deep();
        deep_wake(0);
        deep_wake(1);
        deep_wake(2);
        i_pwr_host_model.cmd(`CMD_DEEP_ENTER);
        cyc(4);
        slp <= 1'b1;
        cyc(6);
        chk({poff, dsw, prot, aux}, 32'h8);
        rdreg(`A_CTRL);
        chk(rd, `CTRL_RST);
        slp <= 1'b0;
        do_reset();
    endtask

    task automatic sleep_wake(input int how);
        pulse_cur(1'b0, 16'h0005);
        rdreg(`A_STAT);
        chk(rd[4:0], 32'h19);
        chk({dsw, dsf, csw, comp, pcs, pds}, 32'h3c);
        case (how)
            0: fault <= 1'b1;
            1: chg_att <= 1'b1;
            2: i_pwr_host_model.cmd(`CMD_SLEEP_EXIT);
            3: vv <= 1'b1;
            default: rsp <= 1'b1;
        endcase
        cyc(2);
        fault <= 1'b0;
        chg_att <= 1'b0;
        vv <= 1'b0;
        rsp <= 1'b0;
        cyc(5);
        rdreg(`A_STAT);
        chk(rd[4:0], 32'h08);
    endtask

    task automatic t_wake();
        wrreg(`A_TIME, 32'h0000_0100);
        wrreg(`A_CTRL, 32'h0000_0014);
        pmv <= 16'h1f40;
        smv <= 16'h1b58;
        pulse_cur(1'b0, 16'h0005);
        tick_gap(2);
        chk(n, `SLEEP_CHECK_MS * 4);
        tick_gap(0);
        chk(n, `MS_PER_S * 4);
        for (int k = 0; k < 5; k++) sleep_wake(k);
    endtask

    task automatic t_pin_shutdown();
        rsp <= 1'b1;
        cyc(4);
        chk({lrst, poff, dsw}, 32'h5);
        cyc(`RST_SHUT_MS * 4 + 8);
        chk({poff, dsw, prot}, 32'h4);
        rsp <= 1'b0;
    endtask

    task automatic give_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        do_reset();
        t_reset_normal();
        t_sleep();
        t_edit();
        t_deep();
        t_wake();
        t_pin_shutdown();
        give_verdict();
    end

    initial begin
        #1000000;
        err_total++;
        give_verdict();
    end
endmodule // battery_monitor_power_modes_bench
